// ### common/clock_mode_pkg.sv
// Shared constants and types for the audio clock-mode controller.
package clock_mode_pkg;

  // Clock modes selected by the PLL power and master/slave bits and, for PLL slave, the PLL reference.
  typedef enum logic [2:0] {
    MODE_PLL_MASTER,
    MODE_PLL_SLAVE_MCLK,
    MODE_PLL_SLAVE_PIN,
    MODE_EXT_SLAVE,
    MODE_EXT_MASTER
  } clk_mode_t;

  // Reference pin that the PLL locks to.
  typedef enum logic [2:0] {
    REF_FRAME,
    REF_BIT32,
    REF_BIT64,
    REF_MCLK,
    REF_NONE
  } pll_ref_t;

  // PLL input-frequency codes.
  localparam logic [3:0] PLL_CODE_FRAME = 4'h0;
  localparam logic [3:0] PLL_CODE_BIT32 = 4'h2;
  localparam logic [3:0] PLL_CODE_BIT64 = 4'h3;
  localparam logic [3:0] PLL_CODE_11M29 = 4'h4;
  localparam logic [3:0] PLL_CODE_12M288 = 4'h5;
  localparam logic [3:0] PLL_CODE_12M_A = 4'h6;
  localparam logic [3:0] PLL_CODE_24M = 4'h7;
  localparam logic [3:0] PLL_CODE_19M2 = 4'h8;
  localparam logic [3:0] PLL_CODE_12M_B = 4'h9;
  localparam logic [3:0] PLL_CODE_13M5 = 4'hc;
  localparam logic [3:0] PLL_CODE_27M = 4'hd;
  localparam logic [3:0] PLL_CODE_13M = 4'he;
  localparam logic [3:0] PLL_CODE_26M = 4'hf;
  localparam logic [3:0] PLL_CODE_RESET = PLL_CODE_12M_B;

  // Master-clock input frequencies in Hz.
  localparam logic [24:0] FREQ_11M29 = 25'd11289600;
  localparam logic [24:0] FREQ_12M288 = 25'd12288000;
  localparam logic [24:0] FREQ_12M = 25'd12000000;
  localparam logic [24:0] FREQ_24M = 25'd24000000;
  localparam logic [24:0] FREQ_19M2 = 25'd19200000;
  localparam logic [24:0] FREQ_13M5 = 25'd13500000;
  localparam logic [24:0] FREQ_27M = 25'd27000000;
  localparam logic [24:0] FREQ_13M = 25'd13000000;
  localparam logic [24:0] FREQ_26M = 25'd26000000;
  localparam logic [24:0] FREQ_NONE = 25'h0;

  // Bit-clock ratio codes for master operation.
  localparam logic [1:0] RATIO_CODE_32 = 2'h1;
  localparam logic [1:0] RATIO_CODE_64 = 2'h2;
  localparam logic [5:0] SLAVE_MIN_BITS = 6'h20;
  localparam logic [5:0] HALF_FRAME_32 = 6'h0f;
  localparam logic [5:0] HALF_FRAME_64 = 6'h1f;

  // Lock times in microseconds and the cycle counts at the reference rate.
  localparam int CLK_FREQ_MHZ = 100;
  localparam int LOCK_FRAME_US = 80000;
  localparam int LOCK_BIT_US = 4000;
  localparam int LOCK_MCLK_US = 40000;
  localparam int LOCK_MCLK_SLOW_US = 60000;
  localparam int LOCK_FRAME_CYC = LOCK_FRAME_US * CLK_FREQ_MHZ;
  localparam int LOCK_BIT_CYC = LOCK_BIT_US * CLK_FREQ_MHZ;
  localparam int LOCK_MCLK_CYC = LOCK_MCLK_US * CLK_FREQ_MHZ;
  localparam int LOCK_MCLK_SLOW_CYC = LOCK_MCLK_SLOW_US * CLK_FREQ_MHZ;
  localparam int LOCK_CNT_W = 24;

endpackage : clock_mode_pkg

// ### core/link_clock_gen.sv
// Bit, frame and master clock generator on the master-clock domain.
`timescale 1ns/100ps
module link_clock_gen
  import clock_mode_pkg::*;
#(
  parameter int HALF_DIV = 4
) (
  // Link clock and reset.
  input wire logic master_clk_i,
  input wire logic rst_i,
  // Levels from the reference domain.
  input wire logic run_i,
  input wire logic wide_i,
  input wire logic mco_run_i,
  // Generated clocks.
  output logic bit_clock_o,
  output logic frame_clock_o,
  output logic master_clock_out_o
);

  if (HALF_DIV < 1 || HALF_DIV > 255) begin : g_chk
    $error("HALF_DIV out of range");
  end

  logic [1:0] rst_pipe_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] lvl_in;
  logic [7:0] div_cnt_reg;
  logic [5:0] bit_cnt_reg;
  logic link_rst;

  assign lvl_in = {mco_run_i, wide_i, run_i};
  assign link_rst = rst_pipe_reg[1];

  // Reset is asserted at once but released on this clock.
  always_ff @(posedge master_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_pipe_reg <= 2'h3;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b0};
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge master_clk_i or posedge rst_i) begin
      if (rst_i) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
      end else begin
        sync1_reg[i] <= lvl_in[i];
        sync2_reg[i] <= sync1_reg[i];
      end
    end
  end

  // A stopped generator parks both clocks low so the first frame is whole.
  always_ff @(posedge master_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_reg <= 8'h0;
      bit_cnt_reg <= 6'h0;
      bit_clock_o <= 1'b0;
      frame_clock_o <= 1'b0;
    end else if (link_rst || !sync2_reg[0]) begin
      div_cnt_reg <= 8'h0;
      bit_cnt_reg <= 6'h0;
      bit_clock_o <= 1'b0;
      frame_clock_o <= 1'b0;
    end else if (div_cnt_reg == 8'(HALF_DIV - 1)) begin
      div_cnt_reg <= 8'h0;
      bit_clock_o <= !bit_clock_o;
      if (bit_clock_o) begin
        if (bit_cnt_reg == (sync2_reg[1] ? HALF_FRAME_64 : HALF_FRAME_32))
        begin
          bit_cnt_reg <= 6'h0;
          frame_clock_o <= !frame_clock_o;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 6'h1;
        end
      end
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h1;
    end
  end

  always_ff @(posedge master_clk_i or posedge rst_i) begin
    if (rst_i) begin
      master_clock_out_o <= 1'b0;
    end else if (link_rst || !sync2_reg[2]) begin
      master_clock_out_o <= 1'b0;
    end else begin
      master_clock_out_o <= !master_clock_out_o;
    end
  end

endmodule : link_clock_gen

// ### core/audio_clock_mode_control.sv
// Clock-mode selection, PLL lock tracking and clock pin control.
//
// Summary of operation
// - PLL on and master selected gives PLL master mode.
// - PLL off gives external-clock slave or master; PLL code ignored.
// - Master/slave bit high means master, low means slave.
// - In and after power-down reset the device is slave, pins inputs.
// - Frame and bit clock pins stay undriven until master bit is set.
// - Master with reference power off drives static level, no toggling.
// - Master with reference power on drives clocks; slave keeps pins inputs.
// - With PLL on, clock rates follow MCLK_HALF_DIV and ratio bits, not PLL code or sample-rate code.
// - Lock wait restarts on PLL power rise and sample-rate change.
// - Output enable, master, PLL off gives invalid clocks on master out.
// - PLL code 0, 2, 3 selects frame, 32fs bit, 64fs bit reference.
// - Master-clock reference codes map to listed input frequencies.
// - External modes take ratio from low rate bits; master out low unless master with output enable.
// - Power-down pin low resets the whole device including mode.
// - PLL master holds frame and bit clocks low until lock.
`timescale 1ns/100ps
module audio_clock_mode_control
  import clock_mode_pkg::*;
#(
  parameter int LOCK_FRAME_CYCLES = LOCK_FRAME_CYC,
  parameter int LOCK_BIT_CYCLES = LOCK_BIT_CYC,
  parameter int LOCK_MCLK_CYCLES = LOCK_MCLK_CYC,
  parameter int LOCK_MCLK_SLOW_CYCLES = LOCK_MCLK_SLOW_CYC,
  parameter int MCLK_HALF_DIV = 4
) (
  // Clocks and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic master_clk_i,
  // Power-down pin.
  input wire logic power_down_reset_n_i,
  // Control bits.
  input wire logic pll_power_on_i,
  input wire logic master_select_i,
  input wire logic reference_power_on_i,
  input wire logic master_out_enable_i,
  input wire logic [3:0] pll_input_freq_code_i,
  input wire logic [3:0] sample_rate_code_i,
  input wire logic [1:0] bit_clock_ratio_code_i,
  // Frame clock pin.
  input wire logic frame_clock_i,
  output logic frame_clock_o,
  output logic frame_clock_oe_o,
  // Bit clock pin.
  input wire logic bit_clock_alt_i,
  output logic bit_clock_alt_o,
  output logic bit_clock_alt_oe_o,
  // Master clock output pin.
  output logic master_clock_out_o,
  // Status.
  output logic [2:0] clock_mode_o,
  output logic [2:0] pll_ref_o,
  output logic [24:0] pll_input_freq_hz_o,
  output logic [1:0] ext_clock_ratio_code_o,
  output logic pll_locked_o,
  output logic pll_code_invalid_o,
  output logic rate_code_invalid_o,
  output logic slave_ratio_error_o
);

  localparam int MAX_LOCK = 2 ** LOCK_CNT_W - 1;

  if (LOCK_FRAME_CYCLES < 1 || LOCK_FRAME_CYCLES > MAX_LOCK ||
      LOCK_BIT_CYCLES < 1 || LOCK_BIT_CYCLES > MAX_LOCK ||
      LOCK_MCLK_CYCLES < 1 || LOCK_MCLK_CYCLES > MAX_LOCK ||
      LOCK_MCLK_SLOW_CYCLES < 1 || LOCK_MCLK_SLOW_CYCLES > MAX_LOCK)
  begin : g_chk
    $error("lock cycle count out of range");
  end

  // Power-down pin synchroniser and pin samplers.
  logic pdn_meta_reg;
  logic pdn_ok_reg;
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] pin_prev_reg;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pdn_meta_reg <= 1'b0;
      pdn_ok_reg <= 1'b0;
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
      pin_prev_reg <= 2'h0;
    end else begin
      pdn_meta_reg <= power_down_reset_n_i;
      pdn_ok_reg <= pdn_meta_reg;
      pin_meta_reg <= {bit_clock_alt_i, frame_clock_i};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Mode decode is purely combinational so pin direction tracks the bits.
  clk_mode_t mode_next;
  pll_ref_t ref_next;
  logic [24:0] freq_next;
  logic code_bad_next;
  logic rate_bad_next;

  always_comb begin
    freq_next = FREQ_NONE;
    code_bad_next = 1'b0;
    case (pll_input_freq_code_i)
      PLL_CODE_FRAME: ref_next = REF_FRAME;
      PLL_CODE_BIT32: ref_next = REF_BIT32;
      PLL_CODE_BIT64: ref_next = REF_BIT64;
      PLL_CODE_11M29, PLL_CODE_12M288, PLL_CODE_12M_A, PLL_CODE_24M,
      PLL_CODE_19M2, PLL_CODE_12M_B, PLL_CODE_13M5, PLL_CODE_27M,
      PLL_CODE_13M, PLL_CODE_26M: ref_next = REF_MCLK;
      default: begin
        ref_next = REF_NONE;
        code_bad_next = 1'b1;
      end
    endcase
    case (pll_input_freq_code_i)
      PLL_CODE_11M29: freq_next = FREQ_11M29;
      PLL_CODE_12M288: freq_next = FREQ_12M288;
      PLL_CODE_12M_A, PLL_CODE_12M_B: freq_next = FREQ_12M;
      PLL_CODE_24M: freq_next = FREQ_24M;
      PLL_CODE_19M2: freq_next = FREQ_19M2;
      PLL_CODE_13M5: freq_next = FREQ_13M5;
      PLL_CODE_27M: freq_next = FREQ_27M;
      PLL_CODE_13M: freq_next = FREQ_13M;
      PLL_CODE_26M: freq_next = FREQ_26M;
      default: freq_next = FREQ_NONE;
    endcase
    // Rate codes 8, 9, 12 and 13 have no meaning on a master-clock reference.
    rate_bad_next = (ref_next == REF_MCLK) && sample_rate_code_i[3] &&
                    !sample_rate_code_i[1];
    if (pll_power_on_i && master_select_i) begin
      mode_next = MODE_PLL_MASTER;
    end else if (pll_power_on_i) begin
      mode_next = (ref_next == REF_MCLK) ? MODE_PLL_SLAVE_MCLK
                                         : MODE_PLL_SLAVE_PIN;
    end else if (master_select_i) begin
      mode_next = MODE_EXT_MASTER;
    end else begin
      mode_next = MODE_EXT_SLAVE;
    end
    if (!pll_power_on_i) begin
      ref_next = REF_NONE;
      freq_next = FREQ_NONE;
      code_bad_next = 1'b0;
      rate_bad_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clock_mode_o <= 3'(MODE_EXT_SLAVE);
      pll_ref_o <= 3'(REF_NONE);
      pll_input_freq_hz_o <= FREQ_NONE;
      pll_code_invalid_o <= 1'b0;
      rate_code_invalid_o <= 1'b0;
      ext_clock_ratio_code_o <= 2'h0;
    end else if (!pdn_ok_reg) begin
      clock_mode_o <= 3'(MODE_EXT_SLAVE);
      pll_ref_o <= 3'(REF_NONE);
      pll_input_freq_hz_o <= FREQ_NONE;
      pll_code_invalid_o <= 1'b0;
      rate_code_invalid_o <= 1'b0;
      ext_clock_ratio_code_o <= 2'h0;
    end else begin
      clock_mode_o <= 3'(mode_next);
      pll_ref_o <= 3'(ref_next);
      pll_input_freq_hz_o <= freq_next;
      pll_code_invalid_o <= code_bad_next;
      rate_code_invalid_o <= rate_bad_next;
      ext_clock_ratio_code_o <= pll_power_on_i ? 2'h0
                                : sample_rate_code_i[1:0];
    end
  end

  // Lock tracking: the count restarts on each PLL power rise or rate change.
  logic pll_prev_reg;
  logic [3:0] rate_prev_reg;
  logic [LOCK_CNT_W-1:0] lock_cnt_reg;
  logic [LOCK_CNT_W-1:0] lock_load;
  logic lock_start;

  always_comb begin
    case (ref_next)
      REF_FRAME: lock_load = LOCK_CNT_W'(LOCK_FRAME_CYCLES);
      REF_BIT32, REF_BIT64: lock_load = LOCK_CNT_W'(LOCK_BIT_CYCLES);
      default: begin
        if (pll_input_freq_code_i == PLL_CODE_13M ||
            pll_input_freq_code_i == PLL_CODE_26M) begin
          lock_load = LOCK_CNT_W'(LOCK_MCLK_SLOW_CYCLES);
        end else begin
          lock_load = LOCK_CNT_W'(LOCK_MCLK_CYCLES);
        end
      end
    endcase
  end

  assign lock_start = pll_power_on_i &&
      (!pll_prev_reg || rate_prev_reg != sample_rate_code_i);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_prev_reg <= 1'b0;
      rate_prev_reg <= 4'h0;
      lock_cnt_reg <= '0;
      pll_locked_o <= 1'b0;
    end else if (!pdn_ok_reg || !pll_power_on_i) begin
      pll_prev_reg <= 1'b0;
      rate_prev_reg <= sample_rate_code_i;
      lock_cnt_reg <= '0;
      pll_locked_o <= 1'b0;
    end else begin
      pll_prev_reg <= 1'b1;
      rate_prev_reg <= sample_rate_code_i;
      if (lock_start) begin
        lock_cnt_reg <= lock_load;
        pll_locked_o <= 1'b0;
      end else if (lock_cnt_reg > LOCK_CNT_W'(1)) begin
        lock_cnt_reg <= lock_cnt_reg - LOCK_CNT_W'(1);
      end else if (lock_cnt_reg == LOCK_CNT_W'(1)) begin
        lock_cnt_reg <= '0;
        pll_locked_o <= !code_bad_next;
      end
    end
  end

  // Pin direction and generator control.
  logic run_reg;
  logic wide_reg;
  logic mco_run_reg;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_clock_oe_o <= 1'b0;
      bit_clock_alt_oe_o <= 1'b0;
      run_reg <= 1'b0;
      wide_reg <= 1'b0;
      mco_run_reg <= 1'b0;
    end else begin
      frame_clock_oe_o <= pdn_ok_reg && master_select_i;
      bit_clock_alt_oe_o <= pdn_ok_reg && master_select_i;
      // With reference power off the pins are driven but held static.
      run_reg <= pdn_ok_reg && master_select_i && reference_power_on_i &&
                 (!pll_power_on_i || pll_locked_o);
      wide_reg <= (bit_clock_ratio_code_i == RATIO_CODE_64);
      // Master out runs in PLL modes and in the PLL master setup case.
      mco_run_reg <= pdn_ok_reg && master_out_enable_i &&
                     (pll_power_on_i || master_select_i);
    end
  end

  // Slave check: count bit clocks between frame rises.
  logic [5:0] slave_bits_reg;
  logic frame_rise;
  logic bit_rise;

  assign frame_rise = pin_sync_reg[0] && !pin_prev_reg[0];
  assign bit_rise = pin_sync_reg[1] && !pin_prev_reg[1];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      slave_bits_reg <= 6'h0;
      slave_ratio_error_o <= 1'b0;
    end else if (!pdn_ok_reg || master_select_i) begin
      slave_bits_reg <= 6'h0;
      slave_ratio_error_o <= 1'b0;
    end else if (frame_rise) begin
      slave_bits_reg <= {5'h0, bit_rise};
      slave_ratio_error_o <= (slave_bits_reg < SLAVE_MIN_BITS);
    end else if (bit_rise && slave_bits_reg != 6'h3f) begin
      slave_bits_reg <= slave_bits_reg + 6'h1;
    end
  end

  link_clock_gen #(
    .HALF_DIV(MCLK_HALF_DIV)
  ) u_gen (
    .master_clk_i(master_clk_i),
    .rst_i(rst_i),
    .run_i(run_reg),
    .wide_i(wide_reg),
    .mco_run_i(mco_run_reg),
    .bit_clock_o(bit_clock_alt_o),
    .frame_clock_o(frame_clock_o),
    .master_clock_out_o(master_clock_out_o)
  );

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_pll_master_mode:
    assert property (pdn_ok_reg && pll_power_on_i && master_select_i
                     |=> clock_mode_o == 3'(MODE_PLL_MASTER))
    else $error("PLL master mode not selected");

  a_ext_mode_pick:
    assert property (pdn_ok_reg && !pll_power_on_i
                     |=> clock_mode_o == ($past(master_select_i) ?
                         3'(MODE_EXT_MASTER) : 3'(MODE_EXT_SLAVE)))
    else $error("external mode not selected");

  a_reset_pins_in:
    assert property (!pdn_ok_reg |=> !frame_clock_oe_o && !bit_clock_alt_oe_o)
    else $error("clock pins driven during power-down");

  a_slave_pins_in:
    assert property (!master_select_i |=> !frame_clock_oe_o ##0
                     !bit_clock_alt_oe_o)
    else $error("clock pins driven in slave mode");

  a_master_pins_out:
    assert property (pdn_ok_reg && master_select_i
                     |=> frame_clock_oe_o && bit_clock_alt_oe_o)
    else $error("clock pins not driven in master mode");

  a_static_no_run:
    assert property (!reference_power_on_i |=> !run_reg)
    else $error("clocks run with reference power off");

  a_hold_till_lock:
    assert property (pll_power_on_i && !pll_locked_o |=> !run_reg)
    else $error("clocks run before PLL lock");

  a_lock_restart:
    assert property (pdn_ok_reg && $rose(pll_power_on_i)
                     |=> !pll_locked_o [*2])
    else $error("lock not restarted on PLL power rise");

  a_lock_after_count:
    assert property ($rose(pll_locked_o) |-> $past(lock_cnt_reg) == 1)
    else $error("lock reported before count expired");

  a_code_invalid:
    assert property (pdn_ok_reg && pll_power_on_i &&
                     pll_input_freq_code_i == 4'h1
                     |=> pll_code_invalid_o && pll_ref_o == 3'(REF_NONE))
    else $error("invalid PLL code not flagged");

  a_freq_decode:
    assert property (pdn_ok_reg && pll_power_on_i &&
                     pll_input_freq_code_i == PLL_CODE_27M
                     |=> pll_input_freq_hz_o == FREQ_27M)
    else $error("input frequency decode wrong");

  a_ext_mco_low:
    assert property (!pll_power_on_i && !master_select_i |=> !mco_run_reg)
    else $error("master out runs in external slave mode");

  a_mco_setup:
    assert property (pdn_ok_reg && master_out_enable_i && master_select_i
                     |=> mco_run_reg)
    else $error("master out idle in PLL master setup");

endmodule : audio_clock_mode_control

// ### verification/host_clock_partner.sv
// Host model that supplies bit and frame clocks while the device is slave.
`timescale 1ns/100ps
module host_clock_partner (
  // Control from the bench.
  input wire logic run_i,
  input wire logic [6:0] bits_i,
  // Clocks towards the device pins.
  output logic bit_o,
  output logic frame_o
);
  int i;

  // Clocks stand low between frames; a frame always finishes whole so the
  // device never sees a clipped frame when the bench stops the host.
  initial begin
    bit_o = 1'b0;
    frame_o = 1'b0;
    forever begin
      wait (run_i);
      for (i = 0; i < int'(bits_i); i++) begin
        if (i == 0 || i == int'(bits_i) / 2) begin
          frame_o = (i == 0);
        end
        #40 bit_o = 1'b1;
        #40 bit_o = 1'b0;
      end
    end
  end
endmodule : host_clock_partner

// ### verification/test_audio_clock_mode_control.sv
// Self-checking bench for the audio clock-mode controller.
`timescale 1ns/100ps
module test_audio_clock_mode_control;
  import clock_mode_pkg::*;
  logic ref_clk_i, rst_i, master_clk_i, pdn_n, pll_on, ms, vref_on, mco_en;
  logic [3:0] pll_code, rate_code;
  logic [1:0] ratio_code;
  logic fr_o, fr_oe, bc_o, bc_oe, mco, locked, code_bad, rate_bad, ratio_err;
  logic [2:0] mode, pref;
  logic [24:0] freq;
  logic [1:0] ext_ratio;
  logic host_run, host_bit, host_frame, fr_pin, bc_pin;
  logic [6:0] host_bits;
  int n_fail, cmp_count, cycles, bit_edges, mco_edges, frame_bits;

  // The host parks its clocks low between frames, as the pull-down would.
  // It always ends a frame whole, so the device never sees a clipped one.
  assign fr_pin = fr_oe ? fr_o : host_frame;
  assign bc_pin = bc_oe ? bc_o : host_bit;

  audio_clock_mode_control #(.LOCK_FRAME_CYCLES(200), .LOCK_BIT_CYCLES(100),
    .LOCK_MCLK_CYCLES(150), .LOCK_MCLK_SLOW_CYCLES(180), .MCLK_HALF_DIV(4)
  ) audio_clock_mode_control_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .master_clk_i(master_clk_i), .power_down_reset_n_i(pdn_n),
    .pll_power_on_i(pll_on), .master_select_i(ms),
    .reference_power_on_i(vref_on), .master_out_enable_i(mco_en),
    .pll_input_freq_code_i(pll_code), .sample_rate_code_i(rate_code),
    .bit_clock_ratio_code_i(ratio_code), .frame_clock_i(fr_pin),
    .frame_clock_o(fr_o), .frame_clock_oe_o(fr_oe), .bit_clock_alt_i(bc_pin),
    .bit_clock_alt_o(bc_o), .bit_clock_alt_oe_o(bc_oe),
    .master_clock_out_o(mco), .clock_mode_o(mode), .pll_ref_o(pref),
    .pll_input_freq_hz_o(freq), .ext_clock_ratio_code_o(ext_ratio),
    .pll_locked_o(locked), .pll_code_invalid_o(code_bad),
    .rate_code_invalid_o(rate_bad), .slave_ratio_error_o(ratio_err));

  host_clock_partner host_clock_partner_inst (.run_i(host_run),
    .bits_i(host_bits), .bit_o(host_bit), .frame_o(host_frame));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    master_clk_i = 1'b0;
    #3;
    forever #7.5 master_clk_i = ~master_clk_i;
  end
  always @(bc_o) bit_edges++;
  always @(mco) mco_edges++;
  always @(posedge bc_o) frame_bits++;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : step

  function automatic logic [24:0] exp_freq(input logic [3:0] c);
    case (c)
      4'h4: return FREQ_11M29;
      4'h5: return FREQ_12M288;
      4'h6, 4'h9: return FREQ_12M;
      4'h7: return FREQ_24M;
      4'h8: return FREQ_19M2;
      4'hc: return FREQ_13M5;
      4'hd: return FREQ_27M;
      4'he: return FREQ_13M;
      4'hf: return FREQ_26M;
      default: return FREQ_NONE;
    endcase
  endfunction : exp_freq

  task automatic t_modes();
    logic [2:0] exp_mode [4] = '{3'h3, 3'h4, 3'h1, 3'h0};
    for (int i = 0; i < 4; i++) begin
      {pll_on, ms} = 2'(i);
      step(4);
      check("mode", mode, exp_mode[i]);
      check("frame_oe", fr_oe, ms);
      check("bit_oe", bc_oe, ms);
    end
  endtask : t_modes

  task automatic t_codes();
    logic [2:0] r;
    ms = 1'b0;
    pll_on = 1'b1;
    for (int c = 0; c < 16; c++) begin
      pll_code = 4'(c);
      step(4);
      r = (c == 0) ? 3'h0 : (c == 2) ? 3'h1 : (c == 3) ? 3'h2 :
          (exp_freq(4'(c)) != FREQ_NONE) ? 3'h3 : 3'h4;
      check("pll_ref", pref, r);
      check("freq", freq, exp_freq(4'(c)));
      check("code_bad", code_bad, c == 1 || c == 10 || c == 11);
      check("slave_mode", mode, r == 3'h3 ? 3'h1 : 3'h2);
      check("rate_ok", rate_bad, 1'b0);
    end
    rate_code = 4'h8;
    step(4);
    check("rate_bad", rate_bad, 1'b1);
    rate_code = 4'hf;
    pll_on = 1'b0;
  endtask : t_codes

  task automatic t_lock();
    logic seen_clk;
    // Master bit is written only after reset has gone.
    ms = 1'b1;
    // Reference power waits for the PLL so no external master clock starts.
    vref_on = 1'b0;
    pll_code = PLL_CODE_12M_B;
    step(4);
    pll_on = 1'b1;
    vref_on = 1'b1;
    seen_clk = 1'b0;
    for (int i = 0; i < 140; i++) begin
      step(1);
      seen_clk |= fr_o | bc_o;
    end
    check("clk_before_lock", seen_clk, 1'b0);
    check("early_lock", locked, 1'b0);
    step(20);
    check("locked", locked, 1'b1);
    bit_edges = 0;
    step(100);
    check("bit_runs", bit_edges != 0, 1'b1);
    rate_code = 4'h3;
    step(3);
    check("relock", locked, 1'b0);
    step(160);
    check("locked_again", locked, 1'b1);
    pll_on = 1'b0;
  endtask : t_lock

  task automatic t_ext();
    {ms, vref_on, mco_en} = 3'b100;
    step(10);
    bit_edges = 0;
    step(100);
    check("static_oe", bc_oe, 1'b1);
    check("static_bits", bit_edges, 0);
    vref_on = 1'b1;
    step(6);
    bit_edges = 0;
    step(100);
    check("active_bits", bit_edges != 0, 1'b1);
    @(posedge fr_o);
    frame_bits = 0;
    @(posedge fr_o);
    check("frame_32", frame_bits, 32);
    step(1);
    ratio_code = 2'h2;
    @(posedge fr_o);
    frame_bits = 0;
    @(posedge fr_o);
    check("frame_64", frame_bits, 64);
    step(1);
    ratio_code = 2'h1;
    mco_en = 1'b1;
    step(6);
    mco_edges = 0;
    step(50);
    check("mco_invalid", mco_edges != 0, 1'b1);
    ms = 1'b0;
    rate_code = 4'hb;
    step(10);
    mco_edges = 0;
    step(50);
    check("mco_low", {mco_edges != 0, mco}, 2'b00);
    check("ext_ratio", ext_ratio, 2'h3);
    mco_en = 1'b0;
  endtask : t_ext

  task automatic t_slave();
    host_bits = 7'd16;
    host_run = 1'b1;
    step(500);
    check("short_frame", ratio_err, 1'b1);
    host_bits = 7'd64;
    step(700);
    check("good_frame", ratio_err, 1'b0);
    host_run = 1'b0;
  endtask : t_slave

  task automatic t_reset_state(input string name);
    check(name, {mode, pref, fr_oe, bc_oe, mco}, {3'h3, 3'h4, 3'h0});
  endtask : t_reset_state

  task automatic t_pdn();
    {ms, vref_on} = 2'b11;
    step(4);
    pdn_n = 1'b0;
    step(6);
    t_reset_state("pdn_state");
    // The same power-down clears the host's mode bits.
    ms = 1'b0;
    pdn_n = 1'b1;
    step(6);
    t_reset_state("pdn_release");
    ms = 1'b1;
    step(4);
    check("master_after_pdn", {fr_oe, bc_oe}, 2'b11);
  endtask : t_pdn

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  initial begin
    {rst_i, pdn_n, pll_on, ms, vref_on, mco_en} = 6'b110010;
    {pll_code, rate_code, ratio_code} = {PLL_CODE_12M_B, 4'hf, 2'h1};
    {host_run, host_bits} = {1'b0, 7'd64};
    n_fail = 0;
    cmp_count = 0;
    cycles = 0;
    bit_edges = 0;
    mco_edges = 0;
    frame_bits = 0;
    step(8);
    rst_i = 1'b0;
    step(6);
    t_reset_state("reset_state");
    t_modes();
    t_codes();
    t_lock();
    t_ext();
    t_slave();
    t_pdn();
    finish_test();
  end
endmodule : test_audio_clock_mode_control
